/* File: hw/iec_pkg.sv */
package iec_pkg;
    // ========================================================
    // register map, indices (byte address is four times index)
    localparam logic [7:0] IEC_IDX_REQ_LOW  = 8'h06; // request reg 0
    localparam logic [7:0] IEC_IDX_REQ_HIGH = 8'h07; // request reg 1
    localparam logic [7:0] IEC_IDX_EN_LOW   = 8'h08; // lower enable
    localparam logic [7:0] IEC_IDX_EN_HIGH  = 8'h09; // upper enable
    localparam logic [7:0] IEC_IDX_ERROR    = 8'h0A; // error flags
    localparam logic [7:0] IEC_IDX_COLL_POS = 8'h0B; // collision position
    localparam logic [7:0] IEC_IDX_CTRL     = 8'h0C; // suppression/multi
    localparam int         IEC_ADDR_W       = 6;     // word address bits
    // ========================================================
    // field positions
    localparam int IEC_SET_BIT       = 7; // set/clear select in requests
    localparam int IEC_INV_BIT       = 7; // pin polarity invert
    localparam int IEC_PUSHPULL_BIT  = 7; // pin driver select
    localparam int IEC_PINEN_BIT     = 6; // pin output enable
    localparam int IEC_CARD_BIT      = 5; // card detect in upper regs
    localparam int IEC_GLOBAL_BIT    = 6; // combined request in reg 1
    localparam int IEC_ERROR_SUMMARY_REQUEST_BIT    = 1; // error summary in reg 0
    localparam int IEC_RECEIVE_DONE_REQUEST_BIT     = 2; // receive done in reg 0
    localparam int IEC_E_NVM         = 7;
    localparam int IEC_E_QWR         = 6;
    localparam int IEC_E_QOVL        = 5;
    localparam int IEC_E_SHORT       = 4;
    localparam int IEC_E_EMPTY       = 3;
    localparam int IEC_E_COLL        = 2;
    localparam int IEC_CTRL_SUPP_BIT = 0; // disturbance suppression
    localparam int IEC_CTRL_MULT_BIT = 1; // multi frame receive
    // ========================================================
    // reset values and frame limits
    localparam logic [7:0] IEC_RST_BYTE     = 8'h00;
    localparam logic [7:0] IEC_MIN_BITS     = 8'h04; // shortest frame
    localparam logic [7:0] IEC_MIN_BYTES    = 8'h03; // with suppression
endpackage : iec_pkg

/* File: hw/iec_req_latch.sv */
// one request register: hardware sets, software sets or clears via bit 7
module iec_req_latch (
    input  wire logic       clk_i,  // system clock
    input  wire logic       rstn_i, // async reset, active low
    input  wire logic [6:0] hw_set_i, // hardware set pulses
    input  wire logic       wr_i,   // software write strobe
    input  wire logic [7:0] wdata_i, // software write data
    output logic      [6:0] req_o   // latched requests
);
    import iec_pkg::*;

    typedef struct packed {
        logic [6:0] req;
    } iec_latch_type;

    iec_latch_type s_q;
    iec_latch_type s_d;

    // ========================================================
    // set wins over a simultaneous software clear
    always_comb begin
        s_d = s_q;
        if (wr_i) begin
            if (wdata_i[IEC_SET_BIT]) begin // [RULE23]
                s_d.req = s_q.req | wdata_i[6:0];
            end else begin
                s_d.req = s_q.req & ~wdata_i[6:0]; // [RULE23]
            end
        end
        s_d.req = s_d.req | hw_set_i;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign req_o = s_q.req;

    AST_REQ_SET_STICKS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (hw_set_i != 7'h00) |=> ((req_o & $past(hw_set_i)) == $past(hw_set_i)))
        else $error("hardware set request not latched"); // [RULE23]
endmodule : iec_req_latch

/* File: hw/iec_err_flags.sv */
// error flag register with event sets and automatic command clears
module iec_err_flags (
    input  wire logic       clk_i,       // system clock
    input  wire logic       rstn_i,      // async reset, active low
    input  wire logic       nvm_done_i,  // nvm command finished pulse
    input  wire logic       nvm_fail_i,  // with that pulse: it failed
    input  wire logic       qwr_err_i,   // queue write in forbidden state
    input  wire logic       qovl_i,      // write attempt while full
    input  wire logic       short_i,     // short frame detected
    input  wire logic       empty_i,     // send due with empty queue
    input  wire logic       coll_i,      // collision outside end symbol
    input  wire logic       cmd_start_i, // new contactless command
    input  wire logic       rx_start_i,  // receive command / wait-for-data
    input  wire logic       multi_i,     // multi frame receive active
    input  wire logic       flags_st_i,  // error flags stored into queue
    output logic      [7:0] err_o        // flags, bits 1..0 read zero
);
    import iec_pkg::*;

    typedef struct packed {
        logic [7:0] err;
    } iec_err_type;

    iec_err_type s_q;
    iec_err_type s_d;

    // ========================================================
    // clears applied first so a same-cycle event still sets
    always_comb begin
        s_d = s_q;
        if (nvm_done_i) begin
            s_d.err[IEC_E_NVM] = nvm_fail_i; // [RULE7]
        end
        if ((cmd_start_i && !multi_i) || (multi_i && flags_st_i)) begin
            s_d.err[IEC_E_QWR] = 1'b0; // [RULE9] [RULE10]
        end
        if (cmd_start_i) begin
            s_d.err[IEC_E_QOVL]  = 1'b0;
            s_d.err[IEC_E_EMPTY] = 1'b0;
        end
        if (rx_start_i) begin
            s_d.err[IEC_E_SHORT] = 1'b0; // [RULE16]
            s_d.err[IEC_E_COLL]  = 1'b0; // [RULE19]
        end
        if (qwr_err_i) s_d.err[IEC_E_QWR] = 1'b1; // [RULE8]
        if (qovl_i) s_d.err[IEC_E_QOVL] = 1'b1; // [RULE11]
        if (short_i) s_d.err[IEC_E_SHORT] = 1'b1; // [RULE13]
        if (empty_i) s_d.err[IEC_E_EMPTY] = 1'b1; // [RULE17]
        if (coll_i) s_d.err[IEC_E_COLL] = 1'b1; // [RULE18]
        s_d.err[1:0] = 2'h0;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign err_o = s_q.err;

    AST_ERR_SHORT_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
        short_i |=> err_o[IEC_E_SHORT]) // [RULE13]
        else $error("short frame flag not set");
    AST_ERR_COLL_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rx_start_i && !coll_i) |=> !err_o[IEC_E_COLL]) // [RULE19]
        else $error("collision flag not cleared at receive start");
    AST_ERR_QWR_MULTI: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (multi_i && err_o[IEC_E_QWR] && !flags_st_i) |=> err_o[IEC_E_QWR])
        else $error("write error cleared before flags stored"); // [RULE10]
endmodule : iec_err_flags

/* File: hw/iec_top.sv */
// ============================================================
// Functional notes
// RULE1: enable-low bit 7 inverts the interrupt pin level.
// RULE2: enable-low bits 6..0 gate request-0 bits into the combined request.
// RULE3: enable-high bit 5 gates the card detect request.
// RULE4: enable-high bits 4..0 gate timer 4..0 underflow requests.
// RULE5: enable-high bit 7: 1 push-pull pin, 0 open-drain pin.
// RULE6: enable-high bit 6 lets combined request reach the pin.
// RULE7: error bit 7 shows last nvm command failed.
// RULE8: error bit 6 on queue write in forbidden states.
// RULE9: queue write error clears when new contactless command starts.
// RULE10: in multi-frame receive it clears only after flags are stored.
// RULE11: error bit 5 on write to full queue; contents kept.
// RULE12: while overflow flag is set every further queue write is dropped.
// RULE13: error bit 4 when frame has fewer than 4 data bits.
// RULE14: such short frame gives no receive request; decoder stays on.
// RULE15: with suppression, frames under 3 bytes are dropped likewise.
// RULE16: short frame flag clears at receive start or wait-for-data.
// RULE17: error bit 3 when send is due with empty queue.
// RULE18: error bit 2 on collision; first position is recorded.
// RULE19: collision flag clears at receive start or wait-for-data.
// RULE20: collision inside end-of-frame symbol does not set the flag.
// RULE21: combined request set when any enabled request is active.
// RULE22: error summary request set by write, overflow, empty or others.
// RULE23: request writes: bit 7 selects set or clear for each 1.
// RULE24: pin = (combined and pin enable) xor invert, push-pull/open-drain.
module iec_top (
    input  wire logic                     clk_i,         // 40 MHz clock
    input  wire logic                     rstn_i,        // async, low
    // avalon-mm slave
    input  wire logic [iec_pkg::IEC_ADDR_W-1:0] avs_address_i, // word addr
    input  wire logic                     avs_read_i,    // read strobe
    input  wire logic                     avs_write_i,   // write strobe
    input  wire logic [31:0]              avs_writedata_i, // write data
    input  wire logic [3:0]               avs_byteenable_i, // lanes
    output logic      [31:0]              avs_readdata_o, // read data
    output logic                          avs_waitrequest_o, // stall
    // request sources, one-cycle pulses
    input  wire logic                     fifo_high_i,   // high alert
    input  wire logic                     fifo_low_i,    // low alert
    input  wire logic                     cmd_done_i,    // command ended
    input  wire logic                     tx_done_i,     // last bit sent
    input  wire logic                     frame_start_i, // sof detected
    input  wire logic                     card_detect_i, // card found
    input  wire logic [4:0]               tmr_underflow_i, // timers 4..0
    // error sources
    input  wire logic                     nvm_done_i,    // nvm cmd end
    input  wire logic                     nvm_fail_i,    // nvm cmd failed
    input  wire logic                     queue_wr_i,    // host queue write
    input  wire logic                     queue_full_i,  // queue is full
    input  wire logic                     wr_forbid_i,   // forbidden state
    input  wire logic                     send_empty_i,  // send, no data
    input  wire logic                     proto_err_i,   // other error
    input  wire logic                     integ_err_i,   // other error
    // receiver
    input  wire logic                     frame_end_i,   // frame complete
    input  wire logic [7:0]               frame_bits_i,  // data bits seen
    input  wire logic [7:0]               frame_bytes_i, // bytes seen
    input  wire logic                     coll_i,        // collision
    input  wire logic                     coll_in_eof_i, // within eof
    input  wire logic [7:0]               coll_pos_i,    // bit position
    input  wire logic                     cmd_start_i,   // new command
    input  wire logic                     rx_start_i,    // rx/wait-for-data
    input  wire logic                     flags_stored_i, // flags in queue
    // outputs
    output logic                          queue_wr_accept_o, // write kept
    output logic                          decoder_on_o,  // rx decoder on
    output logic                          irq_o,         // pin level out
    output logic                          irq_oe_o       // pin drive en
);
    import iec_pkg::*;

    typedef struct packed {
        logic [7:0] en_low;
        logic [7:0] en_high;
        logic [7:0] coll_pos;
        logic       coll_seen;
        logic [1:0] ctrl;
        logic       combined;
        logic [31:0] rdata;
        logic       wait_n;
        logic       accept;
        logic       irq;
        logic       irq_oe;
    } iec_top_type;

    iec_top_type s_q;
    iec_top_type s_d;

    logic [6:0] req_low;
    logic [6:0] req_high;
    logic [7:0] err;
    logic [6:0] set_low;
    logic [6:0] set_high;
    logic       wr_low;
    logic       wr_high;
    logic       bus_wr;
    logic       short_frame;
    logic       coll_valid;
    logic       ovl_hit;
    logic       err_summary;

    // byte-lane write only counts when lane 0 is enabled
    function automatic logic lane_wr(input logic [IEC_ADDR_W-1:0] a,
                                     input logic [7:0] idx);
        lane_wr = bus_wr && (a == idx[IEC_ADDR_W-1:0])
                  && avs_byteenable_i[0];
    endfunction : lane_wr

    // ========================================================
    // bus handshake: every access answered one cycle later
    assign bus_wr  = avs_write_i && !s_q.wait_n;
    assign wr_low  = lane_wr(avs_address_i, IEC_IDX_REQ_LOW);
    assign wr_high = lane_wr(avs_address_i, IEC_IDX_REQ_HIGH);

    // ========================================================
    // frame and queue qualification
    assign short_frame = frame_end_i && ((frame_bits_i < IEC_MIN_BITS) ||
        (s_q.ctrl[IEC_CTRL_SUPP_BIT] && frame_bytes_i < IEC_MIN_BYTES));
    assign coll_valid  = coll_i && !coll_in_eof_i; // [RULE20]
    // overflow flag blocks all later writes until command start
    assign ovl_hit     = queue_wr_i && (queue_full_i || err[IEC_E_QOVL]);
    assign err_summary = (queue_wr_i && wr_forbid_i) || ovl_hit ||
                         send_empty_i || proto_err_i || integ_err_i; // [RULE22]

    // ========================================================
    // hardware set vectors for the two request registers
    always_comb begin
        set_low = 7'h00;
        set_low[6] = fifo_high_i;
        set_low[5] = fifo_low_i;
        set_low[4] = cmd_done_i;
        set_low[3] = tx_done_i;
        // short frames are dropped without a receive request [RULE14] [RULE15]
        set_low[IEC_RECEIVE_DONE_REQUEST_BIT]  = frame_end_i && !short_frame;
        set_low[IEC_ERROR_SUMMARY_REQUEST_BIT] = err_summary; // [RULE22]
        set_low[0] = frame_start_i;
        set_high = 7'h00;
        set_high[IEC_GLOBAL_BIT] = s_q.combined;
        set_high[IEC_CARD_BIT]   = card_detect_i;
        set_high[4:0]            = tmr_underflow_i;
    end

    iec_req_latch u_req_low (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .hw_set_i (set_low),
        .wr_i     (wr_low),
        .wdata_i  (avs_writedata_i[7:0]),
        .req_o    (req_low)
    );

    iec_req_latch u_req_high (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .hw_set_i (set_high),
        .wr_i     (wr_high),
        .wdata_i  (avs_writedata_i[7:0]),
        .req_o    (req_high)
    );

    iec_err_flags u_err (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .nvm_done_i  (nvm_done_i),
        .nvm_fail_i  (nvm_fail_i),
        .qwr_err_i   (queue_wr_i && wr_forbid_i),
        .qovl_i      (queue_wr_i && queue_full_i),
        .short_i     (short_frame && frame_bits_i < IEC_MIN_BITS),
        .empty_i     (send_empty_i),
        .coll_i      (coll_valid),
        .cmd_start_i (cmd_start_i),
        .rx_start_i  (rx_start_i),
        .multi_i     (s_q.ctrl[IEC_CTRL_MULT_BIT]),
        .flags_st_i  (flags_stored_i),
        .err_o       (err)
    );

    // ========================================================
    // registers, combined request and pin
    always_comb begin
        s_d        = s_q;
        s_d.wait_n = (avs_read_i || avs_write_i) && !s_q.wait_n;
        if (lane_wr(avs_address_i, IEC_IDX_EN_LOW))
            s_d.en_low = avs_writedata_i[7:0];
        if (lane_wr(avs_address_i, IEC_IDX_EN_HIGH))
            s_d.en_high = avs_writedata_i[7:0];
        if (lane_wr(avs_address_i, IEC_IDX_CTRL))
            s_d.ctrl = avs_writedata_i[1:0];
        // first collision only; rearmed with the collision flag
        if (rx_start_i) s_d.coll_seen = 1'b0;
        if (coll_valid && !s_q.coll_seen) begin
            s_d.coll_pos  = coll_pos_i; // [RULE18]
            s_d.coll_seen = 1'b1;
        end
        s_d.combined = |(req_low & s_q.en_low[6:0]) // [RULE2] [RULE21]
            || (req_high[IEC_CARD_BIT] && s_q.en_high[IEC_CARD_BIT]) // [RULE3]
            || |(req_high[4:0] & s_q.en_high[4:0]); // [RULE4]
        s_d.irq = (s_q.combined && s_q.en_high[IEC_PINEN_BIT]) // [RULE6]
                  ^ s_q.en_low[IEC_INV_BIT]; // [RULE1] [RULE24]
        // open drain only drives the low level
        s_d.irq_oe = s_q.en_high[IEC_PUSHPULL_BIT] || !s_d.irq; // [RULE5]
        s_d.accept = queue_wr_i && !ovl_hit; // [RULE11] [RULE12]
        s_d.rdata  = 32'h0000_0000;
        if (avs_read_i && !s_q.wait_n) begin
            case (avs_address_i)
                IEC_IDX_REQ_LOW[IEC_ADDR_W-1:0]:
                    s_d.rdata[6:0] = req_low;
                IEC_IDX_REQ_HIGH[IEC_ADDR_W-1:0]:
                    s_d.rdata[6:0] = req_high;
                IEC_IDX_EN_LOW[IEC_ADDR_W-1:0]:
                    s_d.rdata[7:0] = s_q.en_low;
                IEC_IDX_EN_HIGH[IEC_ADDR_W-1:0]:
                    s_d.rdata[7:0] = s_q.en_high;
                IEC_IDX_ERROR[IEC_ADDR_W-1:0]:
                    s_d.rdata[7:0] = err;
                IEC_IDX_COLL_POS[IEC_ADDR_W-1:0]:
                    s_d.rdata[7:0] = s_q.coll_pos;
                IEC_IDX_CTRL[IEC_ADDR_W-1:0]:
                    s_d.rdata[1:0] = s_q.ctrl;
                default: s_d.rdata = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q        <= '0;
            s_q.irq_oe <= 1'b1; // open drain driving low at reset
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata_o    = s_q.rdata;
    assign avs_waitrequest_o = !s_q.wait_n;
    assign queue_wr_accept_o = s_q.accept;
    assign decoder_on_o      = 1'b1; // [RULE14] short frames never stop it
    assign irq_o             = s_q.irq;
    assign irq_oe_o          = s_q.irq_oe;

    // ========================================================
    // checks
    sequence seq_enabled_req;
        |(req_low & s_q.en_low[6:0]);
    endsequence
    AST_COMBINED: assert property (@(posedge clk_i) disable iff (!rstn_i)
        seq_enabled_req |=> s_q.combined) // [RULE21]
        else $error("enabled request missed combined");
    AST_PIN_LEVEL: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ##1 irq_o == (($past(s_q.combined) && $past(s_q.en_high[6]))
                      ^ $past(s_q.en_low[7]))) // [RULE24]
        else $error("pin level wrong");
    AST_OPEN_DRAIN: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!s_q.en_high[7] ##1 irq_o) |-> !irq_oe_o) // [RULE5]
        else $error("open drain drove high");
    AST_PIN_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!s_q.en_high[6] && !s_q.en_low[7]) |=> !irq_o) // [RULE6]
        else $error("pin active while disabled");
    AST_NO_RX_SHORT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        short_frame |-> !set_low[IEC_RECEIVE_DONE_REQUEST_BIT]) // [RULE14]
        else $error("short frame raised receive request");
    AST_OVL_DROP: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (queue_wr_i && err[IEC_E_QOVL]) |=> !queue_wr_accept_o) // [RULE12]
        else $error("write accepted during overflow");
    AST_EOF_COLL: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (coll_i && coll_in_eof_i && !err[IEC_E_COLL]) |=> !err[IEC_E_COLL]) // [RULE20]
        else $error("eof collision counted");
endmodule : iec_top

/* File: testbench/iec_host_model.sv */
// host side of the interrupt pin, with the board pull-up
module iec_host_model (
    input  wire logic irq_i,    // level driven by the block
    input  wire logic irq_oe_i, // block drives the pin
    output logic      pin_o     // level the host sees
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // pin resolution: a released open-drain pin floats to the pull-up
    assign pin_o = irq_oe_i ? irq_i : 1'h1;
endmodule : iec_host_model

/* File: testbench/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import iec_pkg::*;
    // ==========================================================
    // signals, design and host
    logic        clk_i = 1'h0, rstn_i = 1'h0, rd_s = 1'h0, wr_s = 1'h0;
    logic [5:0]  adr = 6'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [20:0] src = 21'h0; // one-cycle event pulses
    logic        nvm_fail = 1'h0, full = 1'h0, forbid = 1'h0;
    logic        in_eof = 1'h0, wreq, accept, dec_on, irq, irq_oe, pin;
    logic [7:0]  nbits = 8'h08, nbytes = 8'h08, cpos = 8'h00;
    int          errors = 0, cmp_count = 0;
    iec_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(adr),
        .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .fifo_high_i(src[6]),
        .fifo_low_i(src[5]), .cmd_done_i(src[4]), .tx_done_i(src[3]),
        .frame_start_i(src[0]), .card_detect_i(src[12]),
        .tmr_underflow_i(src[11:7]), .nvm_done_i(src[13]),
        .nvm_fail_i(nvm_fail), .queue_wr_i(src[14]), .queue_full_i(full),
        .wr_forbid_i(forbid), .send_empty_i(src[15]), .proto_err_i(src[1]),
        .integ_err_i(src[20]), .frame_end_i(src[2]), .frame_bits_i(nbits),
        .frame_bytes_i(nbytes), .coll_i(src[16]), .coll_in_eof_i(in_eof),
        .coll_pos_i(cpos), .cmd_start_i(src[17]), .rx_start_i(src[18]),
        .flags_stored_i(src[19]), .queue_wr_accept_o(accept),
        .decoder_on_o(dec_on), .irq_o(irq), .irq_oe_o(irq_oe));
    iec_host_model host (.irq_i(irq), .irq_oe_i(irq_oe), .pin_o(pin));
    // clock: 25 ns period
    always #12.5 clk_i = ~clk_i;
    // ==========================================================
    // helpers
    task automatic chk8(input string nm, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk8
    // master holds the request until it samples waitrequest low
    task automatic bus(input logic w, input logic [7:0] idx, d,
                       output logic [7:0] q);
        @(posedge clk_i);
        wr_s <= w;
        rd_s <= ~w;
        adr <= idx[5:0];
        wdat <= {24'h0, d};
        @(posedge clk_i);
        // no local limit: only the watchdog ends a stuck access
        while (wreq !== 1'h0) begin
            @(posedge clk_i);
        end
        q = rdat[7:0];
        wr_s <= 1'h0;
        rd_s <= 1'h0;
    endtask : bus
    task automatic wr(input logic [7:0] idx, d);
        logic [7:0] q;
        bus(1'h1, idx, d, q);
    endtask : wr
    task automatic rchk(input string nm, input logic [7:0] idx, e, m);
        logic [7:0] q;
        bus(1'h0, idx, 8'h00, q);
        chk8(nm, e, q & m);
    endtask : rchk
    task automatic pulse(input int s);
        @(posedge clk_i);
        src[s] <= 1'h1;
        @(posedge clk_i);
        src[s] <= 1'h0;
    endtask : pulse
    // pin follows an event three edges later; the pulse task already took one, so two spare for margin
    task automatic settle;
        repeat (4) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    // ==========================================================
    // scenarios
    task automatic t_regs;
        logic [7:0] ix [6] = '{IEC_IDX_EN_LOW, IEC_IDX_EN_HIGH,
            IEC_IDX_ERROR, IEC_IDX_REQ_LOW, IEC_IDX_REQ_HIGH, 8'h3F};
        foreach (ix[i]) rchk("rst", ix[i], 8'h00, 8'hFF);
        wr(8'h3F, 8'hA5);
        wr(IEC_IDX_ERROR, 8'hFF);
        rchk("unmapped", 8'h3F, 8'h00, 8'hFF);
        rchk("err_ro", IEC_IDX_ERROR, 8'h00, 8'hFF);
        wr(IEC_IDX_EN_LOW, 8'h5A);
        wr(IEC_IDX_EN_HIGH, 8'hA5);
        rchk("en_low", IEC_IDX_EN_LOW, 8'h5A, 8'hFF);
        rchk("en_high", IEC_IDX_EN_HIGH, 8'hA5, 8'hFF);
        wr(IEC_IDX_REQ_LOW, 8'h85);
        rchk("req_set", IEC_IDX_REQ_LOW, 8'h05, 8'h7F);
        wr(IEC_IDX_REQ_LOW, 8'h04);
        rchk("req_clr", IEC_IDX_REQ_LOW, 8'h01, 8'h7F);
        $display("t_regs done");
    endtask : t_regs
    // each source alone, once enabled and once with all other sources of its register enabled
    task automatic t_gate;
        logic [7:0] en;
        for (int s = 0; s < 13; s++) begin
            for (int on = 0; on < 2; on++) begin
                en = 8'h01 << (s < 7 ? s : s - 7);
                en = on ? en : ~en;
                wr(IEC_IDX_REQ_LOW, 8'h7F);
                // second clear: combined re-sets bit 6 while it decays
                wr(IEC_IDX_REQ_HIGH, 8'h7F);
                wr(IEC_IDX_REQ_HIGH, 8'h7F);
                wr(IEC_IDX_EN_LOW, s < 7 ? en & 8'h7F : 8'h00);
                wr(IEC_IDX_EN_HIGH, s < 7 ? 8'hC0 : 8'hC0 | en & 8'h3F);
                pulse(s);
                settle();
                chk8("pin", {7'h00, on[0]}, {7'h00, pin});
                rchk("comb", IEC_IDX_REQ_HIGH, {1'h0, on[0], 6'h00}, 8'h40);
            end
        end
        $display("t_gate done");
    endtask : t_gate
    task automatic t_pin;
        logic lv;
        for (int m = 0; m < 4; m++) begin
            for (int on = 0; on < 2; on++) begin
                lv = m[0] ^ on[0];
                wr(IEC_IDX_REQ_HIGH, 8'h7F);
                wr(IEC_IDX_EN_LOW, {m[0], 7'h10});
                wr(IEC_IDX_EN_HIGH, {m[1], on[0], 6'h00});
                pulse(4);
                settle();
                chk8("pin", {7'h00, lv}, {7'h00, pin});
                chk8("oe", {7'h00, m[1] | ~lv}, {7'h00, irq_oe});
            end
        end
        $display("t_pin done");
    endtask : t_pin
    task automatic t_err;
        wr(IEC_IDX_REQ_LOW, 8'h7F);
        pulse(20);
        rchk("integ", IEC_IDX_REQ_LOW, 8'h02, 8'h02);
        in_eof <= 1'h1;
        pulse(16);
        rchk("eof", IEC_IDX_ERROR, 8'h00, 8'hFF);
        in_eof <= 1'h0;
        cpos <= 8'h05;
        pulse(16);
        cpos <= 8'h09;
        pulse(16);
        nvm_fail <= 1'h1;
        pulse(13);
        forbid <= 1'h1;
        pulse(14);
        forbid <= 1'h0;
        full <= 1'h1;
        pulse(14);
        #1 chk8("acc_full", 8'h00, {7'h00, accept});
        full <= 1'h0;
        pulse(14);
        #1 chk8("acc_ovl", 8'h00, {7'h00, accept});
        pulse(15);
        nbits <= 8'h03;
        pulse(2);
        rchk("errs", IEC_IDX_ERROR, 8'hFC, 8'hFF);
        rchk("pos", IEC_IDX_COLL_POS, 8'h05, 8'hFF);
        rchk("no_rx", IEC_IDX_REQ_LOW, 8'h00, 8'h04);
        chk8("dec", 8'h01, {7'h00, dec_on});
        nbits <= 8'h08;
        pulse(17);
        rchk("cmd", IEC_IDX_ERROR, 8'h94, 8'hFF);
        pulse(18);
        rchk("rx", IEC_IDX_ERROR, 8'h80, 8'hFF);
        nvm_fail <= 1'h0;
        pulse(13);
        rchk("nvm_ok", IEC_IDX_ERROR, 8'h00, 8'hFF);
        wr(IEC_IDX_CTRL, 8'h02);
        forbid <= 1'h1;
        pulse(14);
        forbid <= 1'h0;
        pulse(17);
        rchk("multi", IEC_IDX_ERROR, 8'h40, 8'hFF);
        pulse(19);
        rchk("stored", IEC_IDX_ERROR, 8'h00, 8'hFF);
        pulse(14);
        #1 chk8("acc_ok", 8'h01, {7'h00, accept});
        wr(IEC_IDX_CTRL, 8'h01);
        nbytes <= 8'h02;
        pulse(2);
        rchk("supp", IEC_IDX_REQ_LOW, 8'h00, 8'h04);
        nbytes <= 8'h03;
        pulse(2);
        rchk("supp_ok", IEC_IDX_REQ_LOW, 8'h04, 8'h04);
        $display("t_err done");
    endtask : t_err
    // watchdog: the whole run needs well under 5000 cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'h1;
        #1 chk8("pin_rst", 8'h00, {7'h00, pin});
        t_regs();
        t_gate();
        t_pin();
        t_err();
        conclude();
    end
endmodule : tb_top
